// >>> src/short_fault_flag_registers.sv
// Read-only short-circuit fault flag registers for channel groups C to H
//
// Functional notes
// [R1] Flag bit reads 1 on detected short
// [R2] C/D register: C bits 0-2, D 4-6
// [R3] E/F register at ADh, resets 00h
// [R4] E/F register: E bits 0-2, F 4-6
// [R5] G/H register at AEh, resets 00h
// [R6] G/H register: G bits 0-2, H 4-6
// [R7] C/D register at ACh, resets 00h
// [R8] Host writes never change flag contents
module short_fault_flag_registers
(
    input  wire logic                                 ref_clk_in,
    input  wire logic                                 rst_n_in,
    input  wire short_fault_flags_pkg::short_faults_type fault_detect_in,
    input  wire logic                                 rd_en_in,
    input  wire logic                                 wr_en_in,
    input  wire logic [7:0]                           addr_in,
    output logic      [7:0]                           rd_data_out,
    output logic                                      rd_valid_out,
    output logic                                      wr_done_out
);
    import short_fault_flags_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Two groups into one byte, reserved bits forced low
    function automatic logic [7:0] pack_pair(input logic [CH_PER_GROUP-1:0] low_grp,
                                             input logic [CH_PER_GROUP-1:0] high_grp);
        logic [7:0] word;
        word = FLAG_REG_RESET;
        word[LOW_GROUP_LSB +: CH_PER_GROUP]  = low_grp;
        word[HIGH_GROUP_LSB +: CH_PER_GROUP] = high_grp;
        word[LOW_RSVD_BIT]  = 1'b0;
        word[HIGH_RSVD_BIT] = 1'b0;
        return word;
    endfunction

    // ------------------------------------------------------------------
    // Flag state
    // ------------------------------------------------------------------
    short_faults_type flags_q;
    short_faults_type flags_d;
    logic [7:0]       rd_data_q;
    logic [7:0]       rd_data_d;
    logic             rd_valid_q;
    logic             rd_valid_d;
    logic             wr_done_q;
    logic             wr_done_d;

    // Flags follow the detectors; no write path reaches them
    always_comb
    begin
        flags_d = fault_detect_in; // [R1] [R8]
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_valid_d = rd_en_in;
        wr_done_d  = wr_en_in; // [R8]
        rd_data_d  = rd_data_q;
        if (rd_en_in)
        begin
            if (addr_in == ADDR_GROUPS_C_D)
            begin
                rd_data_d = pack_pair(flags_q.group_c, flags_q.group_d); // [R7] [R2]
            end
            else if (addr_in == ADDR_GROUPS_E_F)
            begin
                rd_data_d = pack_pair(flags_q.group_e, flags_q.group_f); // [R3] [R4]
            end
            else if (addr_in == ADDR_GROUPS_G_H)
            begin
                rd_data_d = pack_pair(flags_q.group_g, flags_q.group_h); // [R5] [R6]
            end
            else
            begin
                rd_data_d = FLAG_REG_RESET;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            flags_q    <= FAULTS_RESET; // [R3] [R5] [R7]
            rd_data_q  <= FLAG_REG_RESET;
            rd_valid_q <= 1'b0;
            wr_done_q  <= 1'b0;
        end
        else
        begin
            flags_q    <= flags_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            wr_done_q  <= wr_done_d;
        end
    end

    assign rd_data_out  = rd_data_q;
    assign rd_valid_out = rd_valid_q;
    assign wr_done_out  = wr_done_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_flag_mirror;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> (flags_q == $past(fault_detect_in));
    endproperty
    a_flag_mirror: assert property (p_flag_mirror) // [R1]
        else $error("Flags do not follow detector inputs");

    property p_cd_layout;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_in == ADDR_GROUPS_C_D) |=>
            (rd_valid_out && rd_data_out[2:0] == $past(flags_q.group_c)
             && rd_data_out[6:4] == $past(flags_q.group_d)
             && rd_data_out[3] == 1'b0 && rd_data_out[7] == 1'b0);
    endproperty
    a_cd_layout: assert property (p_cd_layout) // [R2]
        else $error("C/D register layout wrong");

    property p_ef_offset;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_in == ADDR_GROUPS_E_F) |=>
            (rd_valid_out && rd_data_out[2:0] == $past(flags_q.group_e));
    endproperty
    a_ef_offset: assert property (p_ef_offset) // [R3]
        else $error("E/F register not at its offset");

    property p_ef_layout;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_in == ADDR_GROUPS_E_F) |=>
            (rd_data_out[6:4] == $past(flags_q.group_f)
             && rd_data_out[3] == 1'b0 && rd_data_out[7] == 1'b0);
    endproperty
    a_ef_layout: assert property (p_ef_layout) // [R4]
        else $error("E/F register layout wrong");

    property p_gh_offset;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_in == ADDR_GROUPS_G_H) |=>
            (rd_valid_out && rd_data_out[2:0] == $past(flags_q.group_g));
    endproperty
    a_gh_offset: assert property (p_gh_offset) // [R5]
        else $error("G/H register not at its offset");

    property p_gh_layout;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_in == ADDR_GROUPS_G_H) |=>
            (rd_data_out[6:4] == $past(flags_q.group_h)
             && rd_data_out[3] == 1'b0 && rd_data_out[7] == 1'b0);
    endproperty
    a_gh_layout: assert property (p_gh_layout) // [R6]
        else $error("G/H register layout wrong");

    property p_unmapped_zero;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_in != ADDR_GROUPS_C_D && addr_in != ADDR_GROUPS_E_F
         && addr_in != ADDR_GROUPS_G_H) |=> (rd_valid_out && rd_data_out == 8'h00);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) // [R7]
        else $error("Address outside the bank did not read zero");

    property p_write_ignored;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (wr_en_in && !rd_en_in) |=> (wr_done_out && $stable(rd_data_out)
                                     && flags_q == $past(fault_detect_in));
    endproperty
    a_write_ignored: assert property (p_write_ignored) // [R8]
        else $error("Write disturbed flag contents");

    property p_wr_ack;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        wr_en_in |=> wr_done_out;
    endproperty
    a_wr_ack: assert property (p_wr_ack) // [R8]
        else $error("Write not acknowledged");

    property p_read_holds;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !rd_en_in |=> $stable(rd_data_out);
    endproperty
    a_read_holds: assert property (p_read_holds) // [R8]
        else $error("Read data moved without a read");

    property p_rsvd_zero;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        rd_valid_out |-> (rd_data_out[LOW_RSVD_BIT] == 1'b0
                          && rd_data_out[HIGH_RSVD_BIT] == 1'b0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) // [R6]
        else $error("Reserved read data bit set");

    // ------------------------------------------------------------------
    // Reset checks
    // ------------------------------------------------------------------
    // These watch the bank while reset is held, so they carry no disable clause
    property p_cd_reset;
        @(posedge ref_clk_in)
        !rst_n_in |-> (flags_q.group_c == '0 && flags_q.group_d == '0
                       && rd_data_out == FLAG_REG_RESET && !rd_valid_out);
    endproperty
    a_cd_reset: assert property (p_cd_reset) // [R7]
        else $error("C/D register not cleared by reset");

    property p_ef_reset;
        @(posedge ref_clk_in)
        !rst_n_in |-> (flags_q.group_e == '0 && flags_q.group_f == '0
                       && rd_data_out == FLAG_REG_RESET && !wr_done_out);
    endproperty
    a_ef_reset: assert property (p_ef_reset) // [R3]
        else $error("E/F register not cleared by reset");

    property p_gh_reset;
        @(posedge ref_clk_in)
        !rst_n_in |-> (flags_q.group_g == '0 && flags_q.group_h == '0
                       && rd_data_out == FLAG_REG_RESET);
    endproperty
    a_gh_reset: assert property (p_gh_reset) // [R5]
        else $error("G/H register not cleared by reset");

endmodule

// >>> src/short_fault_flags_pkg.sv
// Constants and types shared by the short fault flag register bank
package short_fault_flags_pkg;

    // ------------------------------------------------------------------
    // Register offsets and reset value
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_GROUPS_C_D = 8'hAC;
    localparam logic [7:0] ADDR_GROUPS_E_F = 8'hAD;
    localparam logic [7:0] ADDR_GROUPS_G_H = 8'hAE;
    localparam logic [7:0] FLAG_REG_RESET  = 8'h00;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int LOW_GROUP_LSB  = 0;
    localparam int LOW_RSVD_BIT   = 3;
    localparam int HIGH_GROUP_LSB = 4;
    localparam int HIGH_RSVD_BIT  = 7;
    localparam int CH_PER_GROUP   = 3;

    // ------------------------------------------------------------------
    // Per-channel fault flags, groups C to H
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CH_PER_GROUP-1:0] group_h;
        logic [CH_PER_GROUP-1:0] group_g;
        logic [CH_PER_GROUP-1:0] group_f;
        logic [CH_PER_GROUP-1:0] group_e;
        logic [CH_PER_GROUP-1:0] group_d;
        logic [CH_PER_GROUP-1:0] group_c;
    } short_faults_type;

    localparam short_faults_type FAULTS_RESET = '0;

endpackage

// >>> test/testbench.sv
// Self-checking bench for the short fault flag register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import short_fault_flags_pkg::*;

    // ----------------------------------------------------------------
    // Signals and design instance
    // ----------------------------------------------------------------
    logic             ref_clk_in;
    logic             rst_n_in;
    short_faults_type fault_detect_in;
    logic             rd_en_in;
    logic             wr_en_in;
    logic [7:0]       addr_in;
    logic [7:0]       rd_data_out;
    logic             rd_valid_out;
    logic             wr_done_out;
    int               miscompares = 0;
    int               check_count = 0;
    int               cycles = 0;

    short_fault_flag_registers short_fault_flag_registers_i (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .fault_detect_in(fault_detect_in),
        .rd_en_in(rd_en_in), .wr_en_in(wr_en_in), .addr_in(addr_in),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .wr_done_out(wr_done_out));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in)
    begin
        cycles = cycles + 1;
        if (cycles == 4000)
        begin
            miscompares = miscompares + 1;
            tally_and_finish();
        end
    end

    function automatic logic [7:0] expect_reg(input logic [7:0] a, input short_faults_type f);
        case (a)
            ADDR_GROUPS_C_D: return {1'b0, f.group_d, 1'b0, f.group_c};
            ADDR_GROUPS_E_F: return {1'b0, f.group_f, 1'b0, f.group_e};
            ADDR_GROUPS_G_H: return {1'b0, f.group_h, 1'b0, f.group_g};
            default:         return FLAG_REG_RESET;
        endcase
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Called at a falling edge with the detector levels settled
    task automatic rd(input logic [7:0] a);
        logic [7:0] exp_byte;
        exp_byte = expect_reg(a, fault_detect_in);
        rd_en_in = 1'b1;
        addr_in  = a;
        @(negedge ref_clk_in);
        rd_en_in = 1'b0;
        chk({7'h00, rd_valid_out}, 8'h01);
        chk(rd_data_out, exp_byte);
        @(negedge ref_clk_in);
        chk({7'h00, rd_valid_out}, 8'h00);
        chk(rd_data_out, exp_byte);
    endtask

    task automatic wr(input logic [7:0] a);
        logic [7:0] held;
        held     = rd_data_out;
        wr_en_in = 1'b1;
        addr_in  = a;
        @(negedge ref_clk_in);
        wr_en_in = 1'b0;
        chk({7'h00, wr_done_out}, 8'h01);
        chk(rd_data_out, held);
        @(negedge ref_clk_in);
        chk({7'h00, wr_done_out}, 8'h00);
    endtask

    // Read and write raised in the same cycle
    task automatic rd_wr(input logic [7:0] a);
        rd_en_in = 1'b1;
        wr_en_in = 1'b1;
        addr_in  = a;
        @(negedge ref_clk_in);
        rd_en_in = 1'b0;
        wr_en_in = 1'b0;
        chk({6'h00, rd_valid_out, wr_done_out}, 8'h03);
        chk(rd_data_out, expect_reg(a, fault_detect_in));
        @(negedge ref_clk_in);
    endtask

    // A read on the first edge after release must still see the cleared bank
    task automatic reset_probe(input int hold, input logic [7:0] a);
        rst_n_in = 1'b0;
        repeat (hold) @(negedge ref_clk_in);
        chk(rd_data_out, FLAG_REG_RESET);
        chk({6'h00, rd_valid_out, wr_done_out}, 8'h00);
        fault_detect_in = {18{1'b1}};
        rst_n_in = 1'b1;
        rd_en_in = 1'b1;
        addr_in  = a;
        @(negedge ref_clk_in);
        rd_en_in = 1'b0;
        chk({7'h00, rd_valid_out}, 8'h01);
        chk(rd_data_out, FLAG_REG_RESET);
        @(negedge ref_clk_in);
    endtask

    task automatic settle_and_read(input short_faults_type f);
        fault_detect_in = f;
        @(negedge ref_clk_in);
        rd(ADDR_GROUPS_C_D);
        rd(ADDR_GROUPS_E_F);
        rd(ADDR_GROUPS_G_H);
        rd(8'($urandom_range(255, 175)));
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        fault_detect_in = {18{1'b1}};
        rd_en_in = 1'b0;
        wr_en_in = 1'b0;
        addr_in = 8'h00;
        void'($urandom(32'h42e7));
        reset_probe(4, ADDR_GROUPS_C_D);
        settle_and_read('0);
        for (int i = 0; i < 18; i++)
            settle_and_read(short_faults_type'(18'h0_0001 << i));
        rd(8'hAB);
        rd(8'hAF);
        for (int n = 0; n < 30; n++)
        begin
            fault_detect_in = short_faults_type'(18'($urandom));
            wr(8'($urandom_range(174, 172)));
            settle_and_read(fault_detect_in);
        end
        rd_wr(ADDR_GROUPS_G_H);
        rd_wr(ADDR_GROUPS_C_D);
        fault_detect_in = {18{1'b1}};
        @(negedge ref_clk_in);
        rd(ADDR_GROUPS_G_H);
        reset_probe(1, ADDR_GROUPS_G_H);
        settle_and_read({18{1'b1}});
        rd(ADDR_GROUPS_E_F);
        reset_probe(2, ADDR_GROUPS_E_F);
        settle_and_read(short_faults_type'(18'($urandom)));
        tally_and_finish();
    end
endmodule
